//--- npi_pkg.sv
// constants, carriers and state type for the nand pointer host controller
// Function
// R01: 00h selects bytes 0-255 on x8
// R02: 01h selects bytes 256-511 on x8
// R03: 50h selects spare bytes 512-527 on x8
// R04: 00h and 50h pointer settings persist
// R05: 01h pointer lasts one operation only
// R06: 01h written right before 80h
// R07: 00h or 50h issued sometime before 80h
// R08: x16 has 00h main, 50h spare only
// R09: pointer supplies top column bits, full page
// R10: upper lanes zero in command, address cycles
// R11: select may drop during data transfer
// R12: serial read keeps cle, ale low, we high
// R13: 90h identification yields four ordered bytes
// R14: multi-plane erase repeats setup before D0h
// R15: replace block on program or erase fail; the code only sets fail and records the row in fail_row, with no replacement
// R16: single-bit errors corrected by ecc; the code only keeps an xor of the data words, with no correction
// R17: failed page copied first, block retired; the code only flags fail and records the row in fail_row
// R18: program is 80h, four addresses, data, 10h
// R19: status shows busy on lane 6, fail lane 0
// R20: each read strobe returns next id byte
package npi_pkg;

	// controller register indices on the plain port
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h2;
	localparam logic [3:0] REG_CTRL = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_ID = 4'h5;
	localparam logic [3:0] REG_COLUMN = 4'h6;
	localparam logic [3:0] REG_ROW = 4'h7;
	localparam logic [3:0] REG_ECC = 4'h8;

	// control bits; bits 2..5 are write-only orders
	localparam int CTRL_X16 = 0;
	localparam int CTRL_CE_DC = 1;
	localparam int CTRL_READ = 2;
	localparam int CTRL_ID = 3;
	localparam int CTRL_WAIT = 4;
	localparam int CTRL_CE_REL = 5;

	// status bits
	localparam int ST_BUSY = 0;
	localparam int ST_RB = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_READY = 3;
	localparam int ST_ORDER = 4;
	localparam int ST_AREA = 5;
	localparam int ST_ERASE = 7;
	localparam int ST_PTRSET = 10;

	// device status register lanes
	localparam int DEV_FAIL_LANE = 0;
	localparam int DEV_READY_LANE = 6;

	// device commands
	localparam logic [7:0] CMD_PTR_A = 8'h00;
	localparam logic [7:0] CMD_PTR_B = 8'h01;
	localparam logic [7:0] CMD_PTR_C = 8'h50;
	localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hFF;

	// pointer areas and column bases
	localparam logic [1:0] AREA_A = 2'h0;
	localparam logic [1:0] AREA_B = 2'h1;
	localparam logic [1:0] AREA_C = 2'h2;
	localparam logic [9:0] BASE_B_X8 = 10'h100;
	localparam logic [9:0] BASE_C_X8 = 10'h200;
	localparam logic [9:0] BASE_C_X16 = 10'h100;
	localparam logic [2:0] PROG_ADDR_CYCLES = 3'h4;

	// timing, in ns, and derived cycle counts at sys_clk
	localparam int CLK_NS = 100;
	localparam int T_WP_NS = 40;
	localparam int T_WH_NS = 20;
	localparam int T_WHR_NS = 60;
	localparam int T_RP_NS = 40;
	localparam int T_REH_NS = 20;
	localparam int T_WB_NS = 100;
	localparam int SYNC_CYC = 2;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WH_CYC = (T_WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int REH_CYC = (T_REH_NS + CLK_NS - 1) / CLK_NS;
	localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_WR_CYC = (WHR_CYC > WH_CYC) ? WHR_CYC : WH_CYC;
	localparam int HOLD_RD_CYC = (SYNC_CYC > REH_CYC) ? SYNC_CYC : REH_CYC;

	typedef enum logic [2:0] {
		NPI_IDLE = 3'b000,
		NPI_SETUP = 3'b001,
		NPI_STROBE = 3'b010,
		NPI_HOLD = 3'b011,
		NPI_WAITB = 3'b100,
		NPI_WAITR = 3'b101
	} npi_state_type;

	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic io_oe_n;
		logic [15:0] io_out;
	} npi_pins_out_type;

	typedef struct packed {
		logic rb_n;
		logic [15:0] io_in;
	} npi_pins_in_type;

	typedef struct packed {
		npi_state_type st;
		logic [3:0] cnt;
		logic is_rd;
		logic id_run;
		logic [1:0] id_cnt;
		npi_pins_out_type pins;
		logic rb_s1;
		logic rb_s2;
		logic [15:0] io_s1;
		logic [15:0] io_s2;
		logic [31:0] rdata;
		logic [31:0] id;
		logic [15:0] data;
		logic [15:0] ecc;
		logic [1:0] area;
		logic ptr_set;
		logic [7:0] prev_cmd;
		logic [7:0] last_cmd;
		logic [2:0] addr_cnt;
		logic [9:0] col;
		logic [23:0] row;
		logic [23:0] fail_row;
		logic [2:0] erase_cnt;
		logic x16;
		logic ce_dc;
		logic fail;
		logic ready_bit;
		logic order_err;
	} npi_reg_type;

endpackage

//--- npi_host.sv
// host controller driving an asynchronous nand device through its pins
module npi_host #(
	parameter int ID_BYTES = 4
) (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	// software port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// device pins
	output npi_pkg::npi_pins_out_type pins_out,
	input wire npi_pkg::npi_pins_in_type pins_in
);
	import npi_pkg::*;

	// refused at elaboration: id_cnt is two bits wide
	if (ID_BYTES < 1 || ID_BYTES > 4) begin : g_id_check
		$error("ID_BYTES must be 1 to 4");
	end

	// strobe and hold counters are four bits wide
	if (WP_CYC < 1 || WP_CYC > 16 ||
			RP_CYC < 1 || RP_CYC > 16) begin : g_strobe_check
		$error("strobe width does not fit the cycle counter");
	end

	// longer waits would need a wider cnt field
	if (HOLD_WR_CYC < 1 || HOLD_WR_CYC > 16 ||
			HOLD_RD_CYC < 1 || HOLD_RD_CYC > 16 ||
			WB_CYC < 1 || WB_CYC > 16) begin : g_hold_check
		$error("hold or busy wait does not fit the cycle counter");
	end

	localparam logic [1:0] ID_LAST = 2'(ID_BYTES - 1);
	localparam logic [3:0] WP_LAST = 4'(WP_CYC - 1);
	localparam logic [3:0] RP_LAST = 4'(RP_CYC - 1);
	localparam logic [3:0] HOLD_WR_LAST = 4'(HOLD_WR_CYC - 1);
	localparam logic [3:0] HOLD_RD_LAST = 4'(HOLD_RD_CYC - 1);
	localparam logic [3:0] WB_LAST = 4'(WB_CYC - 1);

	// pins park deselected and released until the first order
	localparam npi_pins_out_type PINS_RESET = '{
		ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
		io_oe_n: 1'b1, io_out: 16'h0000};

	localparam npi_reg_type REG_RESET = '{
		st: NPI_IDLE, cnt: 4'h0, is_rd: 1'b0, id_run: 1'b0, id_cnt: 2'h0,
		pins: PINS_RESET, rb_s1: 1'b0, rb_s2: 1'b0,
		io_s1: 16'h0000, io_s2: 16'h0000, rdata: 32'h00000000,
		id: 32'h00000000, data: 16'h0000, ecc: 16'h0000,
		area: AREA_A, ptr_set: 1'b0, prev_cmd: 8'h00, last_cmd: 8'h00,
		addr_cnt: 3'h0, col: 10'h000, row: 24'h000000,
		fail_row: 24'h000000, erase_cnt: 3'h0, x16: 1'b0, ce_dc: 1'b0,
		fail: 1'b0, ready_bit: 1'b0, order_err: 1'b0};

	npi_reg_type s_q;
	npi_reg_type s_d;

	logic idle;
	logic go_write;
	logic go_read;
	logic [7:0] wbyte;
	logic [15:0] cap;
	logic [9:0] col_now;

	// an id run stays busy across its idle gaps
	assign idle = (s_q.st == NPI_IDLE) && !s_q.id_run;
	assign wbyte = wdata[7:0];
	assign cap = s_q.io_s2;

	// column the device will start from, given the current pointer
	always_comb begin
		col_now = {2'b00, wbyte};
		if (s_q.x16) begin
			if (s_q.area == AREA_C) begin
				col_now = BASE_C_X16 + {7'h00, wbyte[2:0]}; // see R08 R09
			end
		end else if (s_q.area == AREA_B) begin
			col_now = BASE_B_X8 + {2'b00, wbyte}; // see R02 R09
		end else if (s_q.area == AREA_C) begin
			col_now = BASE_C_X8 + {6'h00, wbyte[3:0]}; // see R03 R09
		end
	end

	always_comb begin
		s_d = s_q;
		go_write = 1'b0;
		go_read = 1'b0;
		s_d.rdata = 32'h00000000;

		// pins pass two flops before use
		s_d.rb_s1 = pins_in.rb_n;
		s_d.rb_s2 = s_q.rb_s1;
		s_d.io_s1 = pins_in.io_in;
		s_d.io_s2 = s_q.io_s1;

		// software reads, answered one cycle later
		if (rd) begin
			if (addr == REG_DATA) begin
				s_d.rdata = {16'h0000, s_q.data};
			end else if (addr == REG_CTRL) begin
				s_d.rdata = {30'h0, s_q.ce_dc, s_q.x16};
			end else if (addr == REG_STATUS) begin
				s_d.rdata[ST_BUSY] = !idle;
				s_d.rdata[ST_RB] = s_q.rb_s2;
				s_d.rdata[ST_FAIL] = s_q.fail;
				s_d.rdata[ST_READY] = s_q.ready_bit;
				s_d.rdata[ST_ORDER] = s_q.order_err;
				s_d.rdata[ST_AREA +: 2] = s_q.area;
				s_d.rdata[ST_ERASE +: 3] = s_q.erase_cnt;
				s_d.rdata[ST_PTRSET] = s_q.ptr_set;
			end else if (addr == REG_ID) begin
				s_d.rdata = s_q.id;
			end else if (addr == REG_COLUMN) begin
				s_d.rdata = {22'h0, s_q.col};
			end else if (addr == REG_ROW) begin
				s_d.rdata = {8'h00, s_q.fail_row};
			end else if (addr == REG_ECC) begin
				s_d.rdata = {16'h0000, s_q.ecc};
			end
		end

		// software writes; orders are refused while a cycle runs
		if (wr) begin
			if (addr == REG_CMD && idle) begin
				go_write = 1'b1;
				s_d.pins.cle = 1'b1;
				s_d.pins.io_out = {8'h00, wbyte}; // see R10
				s_d.prev_cmd = wbyte;
				s_d.last_cmd = wbyte;
				s_d.addr_cnt = 3'h0;
				if (wbyte == CMD_PTR_A) begin
					s_d.area = AREA_A; // see R01 R04 R08
					s_d.ptr_set = 1'b1;
					s_d.ecc = 16'h0000;
				end else if (wbyte == CMD_PTR_B && !s_q.x16) begin
					s_d.area = AREA_B; // see R02 R05
					s_d.ptr_set = 1'b1;
					s_d.ecc = 16'h0000;
				end else if (wbyte == CMD_PTR_B) begin
					s_d.order_err = 1'b1; // see R08
				end else if (wbyte == CMD_PTR_C) begin
					s_d.area = AREA_C; // see R03 R04 R08
					s_d.ptr_set = 1'b1;
					s_d.ecc = 16'h0000;
				end else if (wbyte == CMD_SERIAL_IN) begin
					s_d.ecc = 16'h0000;
					// second half needs 01h directly ahead
					if (s_q.area == AREA_B && s_q.prev_cmd != CMD_PTR_B) begin
						s_d.order_err = 1'b1; // see R06
					end
					if (!s_q.ptr_set) begin
						s_d.order_err = 1'b1; // see R07
					end
				end else if (wbyte == CMD_PROG_GO) begin
					if (s_q.last_cmd != CMD_SERIAL_IN ||
							s_q.addr_cnt != PROG_ADDR_CYCLES) begin
						s_d.order_err = 1'b1; // see R18
					end
					s_d.last_cmd = s_q.last_cmd;
				end else if (wbyte == CMD_ERASE_SETUP) begin
					// planes queued ahead of one confirm
					s_d.erase_cnt = s_q.erase_cnt + 3'h1; // see R14
				end else if (wbyte == CMD_ERASE_GO) begin
					if (s_q.erase_cnt == 3'h0) begin
						s_d.order_err = 1'b1; // see R14
					end
					s_d.erase_cnt = 3'h0;
				end else if (wbyte == CMD_RESET) begin
					s_d.area = AREA_A; // see R05
					s_d.erase_cnt = 3'h0;
				end
			end else if (addr == REG_ADDR && idle) begin
				go_write = 1'b1;
				s_d.pins.ale = 1'b1;
				s_d.pins.io_out = {8'h00, wbyte}; // see R10
				s_d.addr_cnt = s_q.addr_cnt + 3'h1;
				if (s_q.last_cmd == CMD_ERASE_SETUP) begin
					// erase takes three row cycles and no column
					s_d.row = {wbyte, s_q.row[23:8]}; // see R14
				end else if (s_q.addr_cnt == 3'h0) begin
					s_d.col = col_now; // see R09
				end else if (s_q.addr_cnt < PROG_ADDR_CYCLES) begin
					s_d.row = {wbyte, s_q.row[23:8]};
				end
			end else if (addr == REG_DATA && idle) begin
				// x8 data keeps the upper lanes at zero
				go_write = 1'b1;
				s_d.pins.io_out = s_q.x16 ? wdata[15:0] : {8'h00, wbyte};
				s_d.ecc = s_q.ecc ^ s_d.pins.io_out; // see R16
			end else if (addr == REG_CTRL) begin
				// mode bits always taken; orders only when idle
				s_d.x16 = wdata[CTRL_X16];
				s_d.ce_dc = wdata[CTRL_CE_DC];
				if (idle) begin
					if (wdata[CTRL_ID]) begin
						s_d.id_run = 1'b1; // see R13
						s_d.id_cnt = 2'h0;
						s_d.id = 32'h00000000;
						go_read = 1'b1;
					end else if (wdata[CTRL_READ]) begin
						go_read = 1'b1;
					end else if (wdata[CTRL_WAIT]) begin
						s_d.st = NPI_WAITB;
						s_d.cnt = 4'h0;
					end else if (wdata[CTRL_CE_REL]) begin
						// ends a sequential read run
						s_d.pins.ce_n = 1'b1; // see R11
					end
				end
			end else if (addr == REG_STATUS) begin
				// write one to clear; a capture in the same cycle wins
				if (wdata[ST_FAIL]) begin
					s_d.fail = 1'b0;
				end
				if (wdata[ST_ORDER]) begin
					s_d.order_err = 1'b0;
				end
			end else if (addr == REG_ECC) begin
				s_d.ecc = 16'h0000;
			end
		end

		// every write cycle selects the part and drives the lanes
		if (go_write) begin
			s_d.st = NPI_SETUP;
			s_d.is_rd = 1'b0;
			s_d.pins.ce_n = 1'b0;
			s_d.pins.io_oe_n = 1'b0;
		end

		// cycle engine
		case (s_q.st)
			NPI_IDLE: begin
				if (s_q.id_run) begin
					go_read = 1'b1; // see R20
				end
			end
			NPI_SETUP: begin
				// latches and data settle a cycle before the strobe
				s_d.st = NPI_STROBE;
				s_d.cnt = 4'h0;
				if (s_q.is_rd) begin
					s_d.pins.re_n = 1'b0;
				end else begin
					s_d.pins.we_n = 1'b0;
				end
			end
			NPI_STROBE: begin
				// one cycle at 100 ns covers the low pulse time
				if (s_q.cnt == (s_q.is_rd ? RP_LAST : WP_LAST)) begin
					s_d.pins.re_n = 1'b1;
					s_d.pins.we_n = 1'b1;
					s_d.st = NPI_HOLD;
					s_d.cnt = 4'h0;
				end else begin
					s_d.cnt = s_q.cnt + 4'h1;
				end
			end
			NPI_HOLD: begin
				if (s_q.cnt == (s_q.is_rd ? HOLD_RD_LAST : HOLD_WR_LAST)) begin
					s_d.st = NPI_IDLE;
					s_d.pins.cle = 1'b0;
					s_d.pins.ale = 1'b0;
					// select may idle high between data cycles
					if (s_q.ce_dc) begin
						s_d.pins.ce_n = 1'b1; // see R11
					end
					if (s_q.is_rd) begin
						s_d.data = s_q.x16 ? cap : {8'h00, cap[7:0]};
						if (s_q.id_run) begin
							s_d.id[8 * s_q.id_cnt +: 8] = cap[7:0]; // see R13
							s_d.id_cnt = s_q.id_cnt + 2'h1;
							if (s_q.id_cnt == ID_LAST) begin
								s_d.id_run = 1'b0;
							end
						end else if (s_q.last_cmd == CMD_STATUS) begin
							s_d.ready_bit = cap[DEV_READY_LANE]; // see R19
							// fail marks the block for replacement
							if (cap[DEV_FAIL_LANE] && cap[DEV_READY_LANE]) begin
								s_d.fail = 1'b1; // see R15 R17
								s_d.fail_row = s_q.row; // see R17
							end
						end else begin
							s_d.ecc = s_d.ecc ^ s_d.data; // see R16
						end
					end
				end else begin
					s_d.cnt = s_q.cnt + 4'h1;
				end
			end
			NPI_WAITB: begin
				// busy may take up to tWB to appear
				if (s_q.cnt == WB_LAST) begin
					s_d.st = NPI_WAITR;
				end else begin
					s_d.cnt = s_q.cnt + 4'h1;
				end
			end
			NPI_WAITR: begin
				if (s_q.rb_s2) begin
					// a single-operation pointer lapses with the busy period
					s_d.st = NPI_IDLE;
					if (s_q.area == AREA_B) begin
						s_d.area = AREA_A; // see R05
					end
				end
			end
			default: begin
				s_d.st = NPI_IDLE;
			end
		endcase

		if (go_read) begin
			// serial output cycle: latches low, write strobe high
			s_d.st = NPI_SETUP;
			s_d.is_rd = 1'b1;
			s_d.pins.ce_n = 1'b0;
			s_d.pins.cle = 1'b0; // see R12
			s_d.pins.ale = 1'b0; // see R12
			s_d.pins.we_n = 1'b1; // see R12
			s_d.pins.io_oe_n = 1'b1;
		end
	end

	// clk_en low freezes every flop, the synchronisers too
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_q <= REG_RESET;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// both outputs come straight from state flops
	assign rdata = s_q.rdata;
	assign pins_out = s_q.pins;

endmodule // npi_host

//--- npi_host_sva.sv
// concurrent checks on the nand host controller pins and port
module npi_host_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// software port
	input wire logic rd,
	input wire logic [31:0] rdata,
	// device pins
	input wire npi_pkg::npi_pins_out_type pins_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import npi_pkg::*;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	chk_rdata_pulse: assert property (
		!$past(rd) |-> rdata == 32'h0) else $error("rdata outside read slot");
	chk_cmd_lanes: assert property (
		pins_out.cle || pins_out.ale |-> !pins_out.io_oe_n &&
		pins_out.io_out[15:8] == 8'h00) else $error("upper lanes not zero");
	chk_read_quiet: assert property (
		!pins_out.re_n |-> !pins_out.cle && !pins_out.ale && pins_out.we_n)
		else $error("latch or write active during read");
	chk_read_float: assert property (
		!pins_out.re_n |-> pins_out.io_oe_n) else $error("host drives in read");
	chk_we_pulse: assert property (
		$fell(pins_out.we_n) |=> $rose(pins_out.we_n))
		else $error("write strobe not one cycle");
	chk_re_gap: assert property (
		$fell(pins_out.re_n) |=> pins_out.re_n [*3])
		else $error("read strobe spacing short");
	chk_cmd_walk: assert property (
		$rose(pins_out.cle) |-> pins_out.we_n ##1 !pins_out.we_n ##1
		pins_out.we_n ##1 !pins_out.cle) else $error("command cycle shape");
	chk_addr_walk: assert property (
		$rose(pins_out.ale) |-> pins_out.we_n ##1 !pins_out.we_n ##1
		pins_out.we_n ##1 !pins_out.ale) else $error("address cycle shape");
	chk_latch_excl: assert property (
		!(pins_out.cle && pins_out.ale)) else $error("both latches high");
	chk_strobe_select: assert property (
		!pins_out.we_n || !pins_out.re_n |-> !pins_out.ce_n)
		else $error("strobe without select");
endmodule // npi_host_sva

bind npi_host npi_host_sva u_npi_host_sva (.sys_clk(sys_clk), .srst(srst),
	.rd(rd), .rdata(rdata), .pins_out(pins_out));

//--- npi_dev_model.sv
// behavioural nand device answering the host controller pins
module npi_dev_model #(
	parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] PART_ID = 8'hC3, // arbitrary value
	parameter logic [7:0] PLANE_ID = 8'h01,
	parameter int BUSY_NS = 3000
) (
	// host side
	input wire npi_pkg::npi_pins_out_type pins_out,
	output npi_pkg::npi_pins_in_type pins_in,
	// fault injection
	input wire logic fail_next
);
	timeunit 1ns;
	timeprecision 1ns;
	import npi_pkg::*;

	logic [1:0] area_q = AREA_A;
	logic [1:0] mode_q = 2'h0;
	logic [1:0] idx_q = 2'h0;
	logic fail_q = 1'b0;
	logic load_q = 1'b0;
	logic [7:0] c;
	logic [7:0] b;
	logic [31:0] id_w;
	assign id_w = {PLANE_ID, 8'hEE, PART_ID, MAKER_ID};
	initial pins_in = '{rb_n: 1'b1, io_in: 16'hA5A5};
	// select only matters at strobe edges, so it may float between
	always @(posedge pins_out.we_n)
		if (!pins_out.ce_n && pins_out.cle) begin
		c = pins_out.io_out[7:0];
		case (c)
			CMD_PTR_A: area_q = AREA_A;
			CMD_PTR_B: area_q = AREA_B;
			CMD_PTR_C: area_q = AREA_C;
			CMD_STATUS: mode_q = 2'h1;
			CMD_READ_ID: begin
				mode_q = 2'h2;
				idx_q = 2'h0;
			end
			CMD_RESET: area_q = AREA_A;
			default: ;
		endcase
		// strobes during busy are missed, as a real part ignores them
		if (c == CMD_ERASE_GO || (load_q && c == CMD_PROG_GO)) begin
			fail_q = fail_next;
			pins_in.rb_n = 1'b0;
			#BUSY_NS;
			pins_in.rb_n = 1'b1;
			if (area_q == AREA_B) area_q = AREA_A;
		end
		load_q = (c == CMD_SERIAL_IN);
	end
	always @(negedge pins_out.re_n) if (!pins_out.ce_n) begin
		case (mode_q)
			2'h1: b = {1'b0, pins_in.rb_n, 5'h00, fail_q};
			2'h2: b = id_w[8 * idx_q +: 8];
			default: b = 8'h96;
		endcase
		if (mode_q == 2'h2) idx_q = idx_q + 2'h1;
		pins_in.io_in = {8'h00, b};
	end
	// no pull on the lanes: once released they show the inverse
	always @(posedge pins_out.re_n) pins_in.io_in <= #20 ~pins_in.io_in;
endmodule // npi_dev_model

//--- npi_host_tb.sv
// self-checking bench for the nand pointer host controller
module npi_host_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import npi_pkg::*;

	localparam logic [7:0] MAKER_ID = 8'hA5; // arbitrary value
	localparam logic [7:0] PART_ID = 8'h3C; // arbitrary value
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fail_next = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] v;
	npi_pins_out_type pins_out;
	npi_pins_in_type pins_in;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] ptr [3] = '{CMD_PTR_A, CMD_PTR_B, CMD_PTR_C};
	logic [9:0] base [3] = '{10'h000, BASE_B_X8, BASE_C_X8};
	// spare area takes only the low four column bits
	logic [9:0] off [3] = '{10'h012, 10'h012, 10'h002};

	always #50 sys_clk = ~sys_clk;

	npi_host u_npi_host (.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pins_out(pins_out), .pins_in(pins_in));
	npi_dev_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) u_npi_dev_model (
		.pins_out(pins_out), .pins_in(pins_in), .fail_next(fail_next));

	task automatic close_out();
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		v = rdata;
	endtask
	// every order is followed by polling busy, bounded
	task automatic op(input logic [3:0] a, input logic [7:0] d);
		int n = 0;
		wr_reg(a, {24'h0, d});
		do begin
			rd_reg(REG_STATUS);
			n++;
		end while (v[ST_BUSY] !== 1'b0 && n < 200);
		if (v[ST_BUSY] !== 1'b0) begin
			failures++;
			$display("unexpected at %0t: controller stuck busy", $time);
		end
	endtask
	task automatic prog(input logic [7:0] c0, r0, r1, r2);
		op(REG_ADDR, c0);
		op(REG_ADDR, r0);
		op(REG_ADDR, r1);
		op(REG_ADDR, r2);
		op(REG_DATA, 8'h11);
		op(REG_DATA, 8'h22);
		rd_reg(REG_ECC);
		check(v, 32'h33);
		op(REG_CMD, CMD_PROG_GO);
		op(REG_CTRL, 8'h10);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		rd_reg(REG_STATUS);
		check({v[ST_PTRSET], v[ST_BUSY], v[6:5]}, 32'h0);
		rd_reg(4'hF);
		check(v, 32'h0);
		for (int i = 0; i < 3; i++) begin
			op(REG_CMD, ptr[i]);
			op(REG_ADDR, 8'h12);
			rd_reg(REG_COLUMN);
			check(v, {22'h0, base[i] + off[i]});
			rd_reg(REG_STATUS);
			check(v[6:5], i[1:0]);
		end
		op(REG_CMD, CMD_PTR_B);
		op(REG_CMD, CMD_SERIAL_IN);
		prog(8'h00, 8'h00, 8'h00, 8'h00);
		rd_reg(REG_STATUS);
		check({v[ST_ORDER], v[6:5]}, 32'h0);
		op(REG_CMD, CMD_PTR_C);
		op(REG_CMD, CMD_SERIAL_IN);
		prog(8'h05, 8'h00, 8'h00, 8'h00);
		rd_reg(REG_STATUS);
		check({v[ST_ORDER], v[6:5]}, {1'b0, AREA_C});
		// pointer b not directly before serial input is refused
		op(REG_CMD, CMD_PTR_B);
		op(REG_CMD, CMD_STATUS);
		op(REG_CMD, CMD_SERIAL_IN);
		rd_reg(REG_STATUS);
		check(v[ST_ORDER], 1'b1);
		op(REG_STATUS, 8'h10);
		op(REG_CMD, CMD_RESET);
		rd_reg(REG_STATUS);
		check({v[ST_ORDER], v[6:5]}, 32'h0);
		repeat (2) begin
			op(REG_CMD, CMD_ERASE_SETUP);
			repeat (3) op(REG_ADDR, 8'h20);
		end
		rd_reg(REG_STATUS);
		check(v[9:7], 3'h2);
		op(REG_CMD, CMD_ERASE_GO);
		op(REG_CTRL, 8'h10);
		op(REG_CMD, CMD_ERASE_GO);
		op(REG_CTRL, 8'h10);
		rd_reg(REG_STATUS);
		check({v[ST_ORDER], v[9:7]}, 32'h8);
		op(REG_STATUS, 8'h10);
		fail_next <= 1'b1;
		op(REG_CMD, CMD_PTR_A);
		op(REG_CMD, CMD_SERIAL_IN);
		prog(8'h00, 8'h34, 8'h12, 8'h01);
		op(REG_CMD, CMD_STATUS);
		op(REG_CTRL, 8'h04);
		rd_reg(REG_STATUS);
		check({v[ST_READY], v[ST_FAIL]}, 32'h3);
		rd_reg(REG_ROW);
		check(v, 32'h0001_1234);
		rd_reg(REG_DATA);
		check(v[7:0], 8'h41);
		fail_next <= 1'b0;
		op(REG_CTRL, 8'h02);
		op(REG_CMD, CMD_PTR_A);
		check(pins_out.ce_n, 1'b1);
		op(REG_CMD, CMD_READ_ID);
		op(REG_ADDR, 8'h00);
		op(REG_CTRL, 8'h0A);
		rd_reg(REG_ID);
		check({v[31:24], v[15:0]}, {8'h01, PART_ID, MAKER_ID});
		op(REG_CTRL, 8'h01);
		op(REG_CMD, CMD_PTR_B);
		rd_reg(REG_STATUS);
		check({v[ST_ORDER], v[6:5]}, 32'h4);
		op(REG_CMD, CMD_PTR_C);
		op(REG_ADDR, 8'h03);
		rd_reg(REG_COLUMN);
		check(v, {22'h0, BASE_C_X16 + 10'h003});
		close_out();
	end
endmodule // npi_host_tb
